// file: rtl/hsl_map.vh
// Purpose: Constants for the host serial link with modem control lines.
// Assumes: Core clock of 125 MHz.
// Notes:   Definitions only.
`ifndef HSL_MAP_VH
`define HSL_MAP_VH
// ***************************************************************
// Framing and timing
// ***************************************************************
`define HSL_CLK_HZ        125000000
`define HSL_DEF_BAUD      115200
`define HSL_DATA_BITS     8
`define HSL_LINE_IDLE     1'b1
`define HSL_START_LEVEL   1'b0
`define HSL_STOP_LEVEL    1'b1
`define HSL_DIV_W         20
// Divisor for the default rate at the core clock, clk/baud - 1.
`define HSL_DEF_DIV       20'h0043C
// ***************************************************************
// Receive state codes
// ***************************************************************
`define HSL_RX_IDLE       2'h0
`define HSL_RX_START      2'h1
`define HSL_RX_DATA       2'h2
`define HSL_RX_STOP       2'h3
`endif

// file: rtl/hsl_top.v
// Purpose: Device end of the main host serial link with RS-232 modem lines.
// Assumes: All inputs synchronous to core_clk; baud_div = clk/baud - 1.
// Notes:   Line names follow the host view.
//
// Operation
// - Rates 300 to 3250000 bit/s chosen by a divisor matched at both ends.
// - Eight wires: data pair, RTS/CTS, DTR/DSR, carrier detect, ring indicate.
// - Host transmit line is our input; host receive line is our output.
// - Clear to send asserted only while a character can be accepted, in command or data mode.
// - Active-low terminal ready blocks sleep, wakes us and selects data mode; release returns to command mode.
// - Ring indicate asserted on incoming call or message events.
// - Carrier detect held while a data connection is in progress.
// - Set ready asserted while the serial interface is on.
`timescale 1ns/10ps
`include "hsl_map.vh"
module hsl_top #(
   parameter [`HSL_DIV_W-1:0] DEF_DIV = `HSL_DEF_DIV
) (
   input  wire                   core_clk,
   input  wire                   reset_n,
   input  wire [`HSL_DIV_W-1:0]  baud_div,
   input  wire                   host_transmit_data_in,
   output wire                   host_receive_data_out,
   input  wire                   host_request_to_send_in,
   output wire                   module_clear_to_send_out,
   input  wire                   terminal_ready_n_in,
   output reg                    set_ready_out,
   output reg                    carrier_detect_out,
   output reg                    ring_indicate_out,
   input  wire                   interface_on,
   input  wire                   connection_active,
   input  wire                   ring_event,
   input  wire                   sleep_request,
   output reg                    sleep_active,
   output reg                    wake_pulse,
   output reg                    command_mode,
   output reg  [7:0]             rx_data,
   output reg                    rx_valid,
   output reg                    rx_frame_error,
   input  wire                   rx_ready,
   input  wire                   tx_valid,
   input  wire [7:0]             tx_data,
   output wire                   tx_ready
);
   // ***************************************************************
   // Receiver
   // ***************************************************************
   reg  [1:0]            st_q;
   reg  [`HSL_DIV_W-1:0] cnt_q;
   reg  [3:0]            bit_q;
   reg  [7:0]            shf_q;
   reg                   dtr_q;
   reg                   ring_q;
   wire [`HSL_DIV_W-1:0] div;

   // A zero divisor is treated as unset and falls back to the default rate.
   assign div = (baud_div == {`HSL_DIV_W{1'b0}}) ? DEF_DIV : baud_div;

   // An unread character blocks new input, so the host is held off first.
   assign module_clear_to_send_out = set_ready_out & ~rx_valid &
                                     (st_q == `HSL_RX_IDLE);

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q           <= `HSL_RX_IDLE;
         cnt_q          <= {`HSL_DIV_W{1'b0}};
         bit_q          <= 4'h0;
         shf_q          <= 8'h00;
         rx_data        <= 8'h00;
         rx_valid       <= 1'b0;
         rx_frame_error <= 1'b0;
      end else begin
         if (rx_valid && rx_ready) begin
            rx_valid <= 1'b0;
         end
         case (st_q)
            `HSL_RX_IDLE: begin
               if (host_transmit_data_in == `HSL_START_LEVEL) begin
                  st_q  <= `HSL_RX_START;
                  cnt_q <= {1'b0, div[`HSL_DIV_W-1:1]};
               end
            end
            `HSL_RX_START: begin
               if (cnt_q != {`HSL_DIV_W{1'b0}}) begin
                  cnt_q <= cnt_q - 1'b1;
               end else if (host_transmit_data_in != `HSL_START_LEVEL) begin
                  st_q <= `HSL_RX_IDLE;
               end else begin
                  st_q  <= `HSL_RX_DATA;
                  cnt_q <= div;
                  bit_q <= 4'h0;
               end
            end
            `HSL_RX_DATA: begin
               if (cnt_q != {`HSL_DIV_W{1'b0}}) begin
                  cnt_q <= cnt_q - 1'b1;
               end else begin
                  shf_q <= {host_transmit_data_in, shf_q[7:1]};
                  cnt_q <= div;
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == 4'h7) begin
                     st_q <= `HSL_RX_STOP;
                  end
               end
            end
            `HSL_RX_STOP: begin
               if (cnt_q != {`HSL_DIV_W{1'b0}}) begin
                  cnt_q <= cnt_q - 1'b1;
               end else begin
                  st_q           <= `HSL_RX_IDLE;
                  rx_data        <= shf_q;
                  rx_valid       <= 1'b1;
                  rx_frame_error <= (host_transmit_data_in != `HSL_STOP_LEVEL);
               end
            end
            default: begin
               st_q <= `HSL_RX_IDLE;
            end
         endcase
      end
   end

   // ***************************************************************
   // Modem control lines
   // ***************************************************************
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         set_ready_out      <= 1'b0;
         carrier_detect_out <= 1'b0;
         ring_indicate_out  <= 1'b0;
         ring_q             <= 1'b0;
         dtr_q              <= 1'b1;
         sleep_active       <= 1'b0;
         wake_pulse         <= 1'b0;
         command_mode       <= 1'b1;
      end else begin
         set_ready_out      <= interface_on;
         carrier_detect_out <= connection_active;
         ring_q             <= ring_event;
         ring_indicate_out  <= ring_event | ring_q;
         dtr_q              <= terminal_ready_n_in;
         wake_pulse         <= sleep_active & ~terminal_ready_n_in;
         if (!terminal_ready_n_in) begin
            sleep_active <= 1'b0;
         end else if (sleep_request) begin
            sleep_active <= 1'b1;
         end
         if (dtr_q && !terminal_ready_n_in) begin
            command_mode <= 1'b0;
         end else if (!dtr_q && terminal_ready_n_in) begin
            command_mode <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // Transmitter
   // ***************************************************************
   hsl_tx u_tx (
      .core_clk                (core_clk),
      .reset_n                 (reset_n),
      .baud_div                (div),
      .host_request_to_send_in (host_request_to_send_in),
      .tx_valid                (tx_valid),
      .tx_data                 (tx_data),
      .tx_ready                (tx_ready),
      .host_receive_data_out   (host_receive_data_out)
   );
endmodule // hsl_top

// file: rtl/hsl_tx.v
// Purpose: Character transmitter toward the host, 8N1, LSB first.
// Assumes: Baud divisor stays stable while a character is in flight.
// Notes:   Start is refused while the host withholds request to send.
`timescale 1ns/10ps
`include "hsl_map.vh"
module hsl_tx (
   input  wire                   core_clk,
   input  wire                   reset_n,
   input  wire [`HSL_DIV_W-1:0]  baud_div,
   input  wire                   host_request_to_send_in,
   input  wire                   tx_valid,
   input  wire [7:0]             tx_data,
   output wire                   tx_ready,
   output reg                    host_receive_data_out
);
   reg  [`HSL_DIV_W-1:0] cnt_q;
   reg  [3:0]            bit_q;
   reg  [8:0]            shf_q;
   reg                   busy_q;

   assign tx_ready = ~busy_q & host_request_to_send_in;

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q                 <= {`HSL_DIV_W{1'b0}};
         bit_q                 <= 4'h0;
         shf_q                 <= 9'h1FF;
         busy_q                <= 1'b0;
         host_receive_data_out <= 1'b1;
      end else if (!busy_q) begin
         host_receive_data_out <= `HSL_LINE_IDLE;
         if (tx_valid && tx_ready) begin
            busy_q                <= 1'b1;
            shf_q                 <= {`HSL_STOP_LEVEL, tx_data};
            host_receive_data_out <= `HSL_START_LEVEL;
            cnt_q                 <= baud_div;
            bit_q                 <= 4'h0;
         end
      end else if (cnt_q != {`HSL_DIV_W{1'b0}}) begin
         cnt_q <= cnt_q - 1'b1;
      end else if (bit_q == 4'h9) begin
         busy_q                <= 1'b0;
         host_receive_data_out <= `HSL_LINE_IDLE;
      end else begin
         host_receive_data_out <= shf_q[0];
         shf_q                 <= {1'b1, shf_q[8:1]};
         bit_q                 <= bit_q + 4'h1;
         cnt_q                 <= baud_div;
      end
   end
endmodule // hsl_tx

// file: verification/hsl_host_model.sv
// Purpose: Host end of the serial link, sending and receiving 8N1 characters.
// Assumes: Bit time of DIV+1 clocks, the same as the device divisor.
// Notes:   Tasks are called by the testbench; lines change at falling edges.
`timescale 1ns/10ps
module hsl_host_model #(parameter int DIV = 7) (
   input  wire logic core_clk,
   input  wire logic host_receive_data_out,
   output logic      host_transmit_data_in
);
   initial host_transmit_data_in = 1'b1;
   task automatic send(input logic [7:0] b, input logic sb = 1'b1);
      logic [9:0] f;
      f = {sb, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(negedge core_clk) host_transmit_data_in <= f[i];
         repeat (DIV) @(negedge core_clk);
      end
      @(negedge core_clk) host_transmit_data_in <= 1'b1;
   endtask
   // Samples mid bit, so a small phase error of the device does not matter.
   task automatic recv(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      while (host_receive_data_out !== 1'b0 && n < 4000) begin
         @(negedge core_clk);
         n++;
      end
      ok = n < 4000;
      repeat ((DIV + 1) / 2 + DIV + 1) @(negedge core_clk);
      for (int i = 0; i < 8; i++) begin
         b[i] = host_receive_data_out;
         repeat (DIV + 1) @(negedge core_clk);
      end
      ok = ok && host_receive_data_out === 1'b1;
   endtask
endmodule // hsl_host_model

// file: verification/hsl_top_properties.sv
// Purpose: Port assertions for the host serial link.
// Assumes: One clock domain with an active-low asynchronous reset.
// Notes:   Attached to hsl_top by the bind at the foot of this file.
`timescale 1ns/10ps
module hsl_top_properties (
   input wire logic core_clk, reset_n, host_receive_data_out, host_request_to_send_in,
   input wire logic module_clear_to_send_out, terminal_ready_n_in, set_ready_out,
   input wire logic carrier_detect_out, ring_indicate_out, interface_on, connection_active,
   input wire logic ring_event, sleep_active, command_mode, rx_valid, tx_valid, tx_ready
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   AST_DSR: assert property (interface_on |=> set_ready_out) else $error("set ready late");
   AST_DCD: assert property (!connection_active |=> !carrier_detect_out) else $error("dcd");
   AST_RI: assert property (ring_event |=> ring_indicate_out [*2]) else $error("ring short");
   AST_CTS: assert property (module_clear_to_send_out |-> set_ready_out && !rx_valid)
      else $error("cts while busy");
   AST_SLEEP: assert property (!terminal_ready_n_in && !sleep_active |=> !sleep_active)
      else $error("slept while terminal ready");
   AST_MODE: assert property ($fell(terminal_ready_n_in) |-> ##[1:3] !command_mode)
      else $error("no data mode");
   AST_RTS: assert property (!host_request_to_send_in |-> !tx_ready) else $error("rts");
   AST_START: assert property (tx_valid && tx_ready |=> !host_receive_data_out)
      else $error("no start bit");
endmodule // hsl_top_properties
bind hsl_top hsl_top_properties u_hsl_top_properties (.core_clk, .reset_n,
   .host_receive_data_out, .host_request_to_send_in, .module_clear_to_send_out,
   .terminal_ready_n_in, .set_ready_out, .carrier_detect_out, .ring_indicate_out,
   .interface_on, .connection_active, .ring_event, .sleep_active, .command_mode, .rx_valid,
   .tx_valid, .tx_ready);

// file: verification/tb_top.sv
// Purpose: Self-checking bench for hsl_top against a host model.
// Assumes: Short bit time of 8 clocks to keep the run brief.
// Notes:   Inputs change at falling edges.
`timescale 1ns/10ps
`include "hsl_map.vh"
module tb_top;
   localparam int DIV = 7;
   logic core_clk = 0, reset_n = 0, host_transmit_data_in, host_receive_data_out;
   logic host_request_to_send_in = 1, module_clear_to_send_out, terminal_ready_n_in = 1;
   logic set_ready_out, carrier_detect_out, ring_indicate_out, interface_on = 0;
   logic connection_active = 0, ring_event = 0, sleep_request = 0, sleep_active, wake_pulse;
   logic command_mode, rx_valid, rx_frame_error, rx_ready = 0, tx_valid = 0, tx_ready, ok;
   logic [7:0] rx_data, tx_data = 8'h00, b;
   logic [`HSL_DIV_W-1:0] baud_div = DIV;
   int fail_count = 0, n_checks = 0, cyc = 0;
   always #4 core_clk = ~core_clk;
   hsl_top u_hsl_top (.core_clk, .reset_n, .baud_div, .host_transmit_data_in,
      .host_receive_data_out, .host_request_to_send_in, .module_clear_to_send_out,
      .terminal_ready_n_in, .set_ready_out, .carrier_detect_out, .ring_indicate_out,
      .interface_on, .connection_active, .ring_event, .sleep_request, .sleep_active,
      .wake_pulse, .command_mode, .rx_data, .rx_valid, .rx_frame_error, .rx_ready,
      .tx_valid, .tx_data, .tx_ready);
   hsl_host_model #(.DIV(DIV)) u_hsl_host_model (.core_clk, .host_receive_data_out,
      .host_transmit_data_in);
   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic c, input string m);
      n_checks++;
      if (c !== 1'b1) begin
         fail_count++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   // Leaves tx_valid high so that a following byte is offered without a gap.
   task automatic put(input logic [7:0] d);
      int n;
      n = 0;
      tx_data = d;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1 && n < 2000) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
   endtask
   task t_modem;
      @(negedge core_clk) {interface_on, connection_active, ring_event} = 3'b111;
      @(negedge core_clk) ring_event = 1'b0;
      chk(set_ready_out === 1'b1 && carrier_detect_out === 1'b1, "status");
      chk(ring_indicate_out === 1'b1 && module_clear_to_send_out === 1'b1, "ri cts");
      @(negedge core_clk) connection_active = 1'b0;
      chk(ring_indicate_out === 1'b1, "ring stretch");
      @(negedge core_clk);
      chk(carrier_detect_out === 1'b0 && ring_indicate_out === 1'b0, "off");
   endtask
   task t_tx;
      logic [7:0] b0;
      logic       ok0;
      fork
         begin put(8'hA5); put(8'h3C); tx_valid = 1'b0; end
         begin u_hsl_host_model.recv(b0, ok0); u_hsl_host_model.recv(b, ok); end
      join
      chk(b0 === 8'hA5 && b === 8'h3C && ok === 1'b1 && ok0 === 1'b1, "tx bytes");
   endtask
   task t_rts;
      @(negedge core_clk) host_request_to_send_in = 1'b0;
      tx_data = 8'h81;
      tx_valid = 1'b1;
      repeat (20) @(negedge core_clk) chk(!tx_ready && host_receive_data_out, "held");
      fork
         begin host_request_to_send_in = 1'b1; put(8'h81); tx_valid = 1'b0; end
         u_hsl_host_model.recv(b, ok);
      join
      chk(b === 8'h81 && ok === 1'b1, "resume");
   endtask
   task t_rx;
      u_hsl_host_model.send(8'h5A);
      for (int n = 0; n < 200 && rx_valid !== 1'b1; n++) @(negedge core_clk);
      chk(rx_data === 8'h5A && rx_frame_error === 1'b0, "rx byte");
      chk(module_clear_to_send_out === 1'b0, "cts pending");
      rx_ready = 1'b1;
      @(negedge core_clk) rx_ready = 1'b0;
      @(negedge core_clk) chk(!rx_valid && module_clear_to_send_out, "consumed");
      u_hsl_host_model.send(8'hC3, 1'b0);
      for (int n = 0; n < 200 && rx_valid !== 1'b1; n++) @(negedge core_clk);
      chk(rx_data === 8'hC3 && rx_frame_error === 1'b1, "bad stop");
      rx_ready = 1'b1;
      @(negedge core_clk) rx_ready = 1'b0;
      repeat (12) @(negedge core_clk);
      chk(!rx_valid && module_clear_to_send_out, "glitch ignored");
   endtask
   task t_dtr;
      sleep_request = 1'b1;
      repeat (3) @(negedge core_clk);
      chk(sleep_active === 1'b1 && command_mode === 1'b1, "sleep");
      terminal_ready_n_in = 1'b0;
      @(negedge core_clk) chk(wake_pulse === 1'b1, "wake");
      repeat (3) @(negedge core_clk);
      chk(sleep_active === 1'b0 && command_mode === 1'b0, "data mode");
      {terminal_ready_n_in, sleep_request} = 2'b10;
      repeat (4) @(negedge core_clk) chk(command_mode === 1'b1 || cyc < 0, "cmd");
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         print_verdict;
      end
   end
   initial begin
      repeat (16) @(negedge core_clk);
      chk(host_receive_data_out === 1'b1 && command_mode === 1'b1, "reset");
      reset_n = 1'b1;
      t_modem;
      t_tx;
      t_rts;
      t_rx;
      t_dtr;
      print_verdict;
   end
endmodule // tb_top
